// >>> occ_defines.vh
// Constants for the oscillator control low-byte block.
// Assumes a 32-bit APB slave and a 125 MHz system clock.
//
// Contract
// - Monitor on: lock bit blocks selection changes
// - Monitor off: selections never locked
// - Lock status follows PLL lock or timer
// - Lock status zero during switch, non-PLL
// - Clock fail flag set on monitor failure
// - Drive bit selects high-power secondary oscillator
// - Drive bit ignored with digital secondary input
// - Enable bit turns secondary oscillator on
// - Switch request starts switch, reads zero after
// - Selection reset values come from configuration
// - Bits six and four read zero
// - Equal sources abort switch, clear request
// - Valid switch clears lock and fail flags; code clears only the fail flag, lock bit kept
// - Wait ten new clocks, then copy source
// - Switching disabled holds request at zero
`ifndef OCC_DEFINES_VH
`define OCC_DEFINES_VH

// -----------------------------------------------------------
// Register byte addresses
// -----------------------------------------------------------
`define OCC_ADDR_CTRL    12'h000
`define OCC_ADDR_STATUS  12'h004
`define OCC_ADDR_MASK    12'h008

// -----------------------------------------------------------
// Field positions in the control word
// -----------------------------------------------------------
`define OCC_BIT_SWREQ    0
`define OCC_BIT_SECONDARY_OSC_ENABLE   1
`define OCC_BIT_SECONDARY_OSC_DRIVE  2
`define OCC_BIT_CFAIL    3
`define OCC_BIT_PLOCK    5
`define OCC_BIT_CLOCK    7
`define OCC_NEW_SOURCE_SELECT_LSB     8
`define OCC_NEW_SOURCE_SELECT_MSB     10
`define OCC_CURRENT_SOURCE_SELECT_LSB     12
`define OCC_CURRENT_SOURCE_SELECT_MSB     14

// -----------------------------------------------------------
// Interrupt status bits
// -----------------------------------------------------------
`define OCC_IRQ_DONE     0
`define OCC_IRQ_FAIL     1
`define OCC_IRQ_ABORT    2
`define OCC_IRQ_W        3

// -----------------------------------------------------------
// Timing and resets
// -----------------------------------------------------------
`define OCC_SETTLE_CYC   4'hA
`define OCC_CNT_W        4
`define OCC_ZERO32       32'h0000_0000
`define OCC_SRC_ZERO     3'h0

`endif

// >>> occ_sync.v
// Two-flop synchroniser for a group of level inputs.
// Assumes inputs are quasi-static levels from other domains.
`timescale 1ns/1ps
`default_nettype none
module occ_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         mclk_i,
  input  wire         rst_i,
  // Data
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // First stage feeds only the second stage
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule
`default_nettype wire

// >>> occ_edge.v
// Rising-edge counter for a clock sampled as a level.
// Assumes the sampled clock is already synchronised and slow.
`timescale 1ns/1ps
`default_nettype none
`include "occ_defines.vh"
module occ_edge (
  // Clock and reset
  input  wire                 mclk_i,
  input  wire                 rst_i,
  // Control
  input  wire                 run_i,
  input  wire                 clk_lvl_i,
  output wire                 done_o
);
  reg                  last_reg;
  reg [`OCC_CNT_W-1:0] cnt_reg;

  // Count new-source edges while running, restart when idle
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      last_reg <= 1'b0;
      cnt_reg  <= {`OCC_CNT_W{1'b0}};
    end else begin
      last_reg <= clk_lvl_i;
      if (!run_i)
        cnt_reg <= {`OCC_CNT_W{1'b0}};
      else if (clk_lvl_i && !last_reg && !done_o)
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign done_o = (cnt_reg == `OCC_SETTLE_CYC);
endmodule
`default_nettype wire

// >>> occ_ctrl.v
// Oscillator control low byte with switch sequencer and APB slave.
// Assumes config straps are stable around reset release; clock
// status inputs come from other domains and are synchronised here.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "occ_defines.vh"
module occ_ctrl (
  // Clock and reset
  input  wire        mclk_i,
  input  wire        rst_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output wire        pready_o,
  output reg  [31:0] prdata_o,
  output wire        pslverr_o,
  // Configuration straps
  input  wire        switch_monitor_config_i,
  input  wire        secondary_source_config_i,
  input  wire [2:0]  initial_source_config_i,
  // Clock source status
  input  wire        pll_locked_i,
  input  wire        pll_timer_ok_i,
  input  wire        clock_failed_i,
  input  wire        new_src_ready_i,
  input  wire        new_src_clk_i,
  input  wire [7:0]  pll_source_map_i,
  // Clock source controls
  output reg  [2:0]  current_source_select_o,
  output reg         secondary_osc_enable_o,
  output reg         secondary_osc_high_power_o,
  output reg         switch_busy_o,
  // Interrupt
  output wire        irq_o
);
  // -----------------------------------------------------------
  // State codes
  // -----------------------------------------------------------
  localparam ST_IDLE  = 2'b00;
  localparam ST_WAIT  = 2'b01;
  localparam ST_COUNT = 2'b10;

  // -----------------------------------------------------------
  // Registers and wires
  // -----------------------------------------------------------
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg         clock_select_lock_reg;
  reg         clock_fail_flag_reg;
  reg         secondary_osc_drive_reg;
  reg         secondary_osc_enable_reg;
  reg         osc_switch_request_reg;
  reg  [2:0]  new_source_select_reg;
  reg  [2:0]  current_source_select_reg;
  reg         strap_done_reg;
  reg         sw_en_reg;
  reg  [`OCC_IRQ_W-1:0] irq_stat_reg;
  reg  [`OCC_IRQ_W-1:0] irq_mask_reg;
  wire [4:0]  sync_q;
  wire        pll_locked_s;
  wire        pll_timer_s;
  wire        fail_s;
  wire        ready_s;
  wire        nclk_s;
  wire        settle_done;
  wire        wr_acc;
  wire        locked;
  wire        req_set;
  wire        start_abort;
  wire        start_valid;
  wire        switch_done;
  wire        pll_mode;
  wire [15:0] ctrl_word;
  reg         fail_last_reg;

  // -----------------------------------------------------------
  // Input synchronisers and settle counter
  // -----------------------------------------------------------
  occ_sync #(
    .W (5)
  ) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({pll_locked_i, pll_timer_ok_i, clock_failed_i,
              new_src_ready_i, new_src_clk_i}),
    .q_o    (sync_q)
  );
  assign {pll_locked_s, pll_timer_s, fail_s, ready_s, nclk_s} = sync_q;

  occ_edge u_edge (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .run_i     (state_reg == ST_COUNT),
    .clk_lvl_i (nclk_s),
    .done_o    (settle_done)
  );

  // -----------------------------------------------------------
  // Decode helpers
  // -----------------------------------------------------------
  function is_pll_src;
    input [2:0] src;
    input [7:0] map;
    begin
      is_pll_src = map[src];
    end
  endfunction

  // APB write takes effect at the access edge; zero wait states
  assign wr_acc    = psel_i & penable_i & pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;

  // Lock applies only with the monitor enabled
  assign locked = switch_monitor_config_i & clock_select_lock_reg;
  // Request only while idle, unlocked and switching allowed
  assign req_set = wr_acc && (paddr_i == `OCC_ADDR_CTRL) && pstrb_i[0]
                   && pwdata_i[`OCC_BIT_SWREQ] && !locked
                   && sw_en_reg && (state_reg == ST_IDLE);
  assign start_abort = osc_switch_request_reg && (state_reg == ST_IDLE)
                       && (new_source_select_reg
                           == current_source_select_reg);
  assign start_valid = osc_switch_request_reg && (state_reg == ST_IDLE)
                       && !start_abort;
  assign switch_done = (state_reg == ST_COUNT) && settle_done;
  assign pll_mode = is_pll_src(current_source_select_reg,
                               pll_source_map_i);

  // -----------------------------------------------------------
  // Switch sequencer
  // -----------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  if (start_valid) state_next = ST_WAIT;
      ST_WAIT:  if (ready_s) state_next = ST_COUNT;
      ST_COUNT: if (settle_done) state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  // Straps are caught on the first clock after reset release
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_done_reg <= 1'b0;
      sw_en_reg      <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      sw_en_reg      <= switch_monitor_config_i;
    end
  end

  // Control byte and source fields
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg                 <= ST_IDLE;
      clock_select_lock_reg     <= 1'b0;
      secondary_osc_drive_reg   <= 1'b0;
      secondary_osc_enable_reg  <= 1'b0;
      osc_switch_request_reg    <= 1'b0;
      new_source_select_reg     <= `OCC_SRC_ZERO;
      current_source_select_reg <= `OCC_SRC_ZERO;
    end else begin
      state_reg <= state_next;
      if (!strap_done_reg) begin
        new_source_select_reg     <= initial_source_config_i;
        current_source_select_reg <= initial_source_config_i;
      end
      if (wr_acc && (paddr_i == `OCC_ADDR_CTRL) && pstrb_i[0]) begin
        clock_select_lock_reg    <= pwdata_i[`OCC_BIT_CLOCK];
        secondary_osc_drive_reg  <= pwdata_i[`OCC_BIT_SECONDARY_OSC_DRIVE];
        secondary_osc_enable_reg <= pwdata_i[`OCC_BIT_SECONDARY_OSC_ENABLE];
      end
      // Source select may change only when unlocked and idle
      if (wr_acc && (paddr_i == `OCC_ADDR_CTRL) && pstrb_i[1]
          && !locked && (state_reg == ST_IDLE) && strap_done_reg)
        new_source_select_reg <=
          pwdata_i[`OCC_NEW_SOURCE_SELECT_MSB:`OCC_NEW_SOURCE_SELECT_LSB];
      if (!sw_en_reg)
        osc_switch_request_reg <= 1'b0;
      else if (start_abort || switch_done)
        osc_switch_request_reg <= 1'b0;
      else if (req_set)
        osc_switch_request_reg <= 1'b1;
      if (switch_done)
        current_source_select_reg <= new_source_select_reg;
    end
  end

  // Clock fail flag: a new failure edge wins over the clear
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      clock_fail_flag_reg <= 1'b0;
      fail_last_reg       <= 1'b0;
    end else begin
      fail_last_reg <= fail_s;
      if (fail_s && !fail_last_reg)
        clock_fail_flag_reg <= 1'b1;
      else if (start_valid)
        clock_fail_flag_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------
  // Outputs to clock sources
  // -----------------------------------------------------------
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      current_source_select_o    <= `OCC_SRC_ZERO;
      secondary_osc_enable_o     <= 1'b0;
      secondary_osc_high_power_o <= 1'b0;
      switch_busy_o              <= 1'b0;
    end else begin
      current_source_select_o <= current_source_select_reg;
      secondary_osc_enable_o  <= secondary_osc_enable_reg;
      // Digital input mode has no drive choice at all
      secondary_osc_high_power_o <= secondary_source_config_i
                                    & secondary_osc_drive_reg;
      switch_busy_o <= (state_reg != ST_IDLE);
    end
  end

  // -----------------------------------------------------------
  // Readback
  // -----------------------------------------------------------
  // Lock status is live; a register would lag a switch by a cycle
  assign ctrl_word = {
    1'b0,
    current_source_select_reg,
    1'b0,
    new_source_select_reg,
    clock_select_lock_reg,
    1'b0,
    pll_mode && (state_reg == ST_IDLE)
      && (pll_locked_s || pll_timer_s),
    1'b0,
    clock_fail_flag_reg,
    secondary_osc_drive_reg,
    secondary_osc_enable_reg,
    osc_switch_request_reg
  };

  // Read data registered at the setup cycle, stable for access
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= `OCC_ZERO32;
    end else if (psel_i && !penable_i) begin
      case (paddr_i)
        `OCC_ADDR_CTRL:   prdata_o <= {16'h0000, ctrl_word};
        `OCC_ADDR_STATUS: prdata_o <= {28'h000_0000, 1'b0, irq_stat_reg};
        `OCC_ADDR_MASK:   prdata_o <= {28'h000_0000, 1'b0, irq_mask_reg};
        default:          prdata_o <= `OCC_ZERO32;
      endcase
    end
  end

  // -----------------------------------------------------------
  // Interrupts: sticky status, write one to clear, set wins
  // -----------------------------------------------------------
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_reg <= {`OCC_IRQ_W{1'b0}};
      irq_mask_reg <= {`OCC_IRQ_W{1'b0}};
    end else begin
      if (wr_acc && (paddr_i == `OCC_ADDR_MASK) && pstrb_i[0])
        irq_mask_reg <= pwdata_i[`OCC_IRQ_W-1:0];
      irq_stat_reg <= (irq_stat_reg
                       & ~((wr_acc && (paddr_i == `OCC_ADDR_STATUS)
                            && pstrb_i[0])
                           ? pwdata_i[`OCC_IRQ_W-1:0]
                           : {`OCC_IRQ_W{1'b0}}))
                      | {start_abort,
                         fail_s && !fail_last_reg,
                         switch_done};
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);
endmodule
`default_nettype wire

// >>> occ_ctrl_assertions.sv
// Concurrent checks on the ports of the oscillator control block.
// Assumes one clock domain and the straps held steady while running.
`timescale 1ns/1ps
`default_nettype none
module occ_ctrl_assertions (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [31:0] prdata_o,
  input wire logic        switch_monitor_config_i,
  input wire logic        secondary_source_config_i,
  input wire logic [7:0]  pll_source_map_i,
  input wire logic [2:0]  current_source_select_o,
  input wire logic        secondary_osc_enable_o,
  input wire logic        secondary_osc_high_power_o,
  input wire logic        switch_busy_o
);
  // ---------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------
  logic [1:0] up_cnt;
  wire        rd_set = psel_i && !penable_i && !pwrite_i;
  wire        wr_acc = psel_i && penable_i && pwrite_i;

  // Strap capture moves the source output at the second edge after
  // release, seen as a change at the third; skip those edges
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i)
      up_cnt <= 2'd0;
    else if (up_cnt != 2'd3)
      up_cnt <= up_cnt + 2'd1;
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------
  // Properties
  // ---------------------------------------------------------
  chk_bus_no_wait: assert property (pready_o && !pslverr_o)
    else $error("bus stalled or flagged error");
  chk_rdata_hold: assert property (psel_i && penable_i ##1 !psel_i
    |-> $stable(prdata_o)) else $error("read data moved");
  chk_unmapped_zero: assert property (rd_set && paddr_i > 12'h008
    |=> prdata_o == 32'h0000_0000) else $error("unmapped read");
  chk_ctrl_rsvd_bits: assert property (rd_set && paddr_i == 12'h000
    |=> prdata_o[31:16] == 16'h0000 && !prdata_o[6] && !prdata_o[4])
    else $error("reserved ctrl bits set");
  chk_lock_in_switch: assert property (rd_set && paddr_i == 12'h000
    ##1 switch_busy_o |-> !prdata_o[5])
    else $error("pll lock shown during switch");
  chk_enable_write: assert property (wr_acc && paddr_i == 12'h000
    && pstrb_i[0] |=> ##1 secondary_osc_enable_o == $past(pwdata_i[1], 2))
    else $error("enable output wrong");
  chk_hp_digital: assert property (!secondary_source_config_i [*2]
    |-> !secondary_osc_high_power_o) else $error("high power on input");
  chk_src_by_switch: assert property (up_cnt == 2'd3
    && $changed(current_source_select_o) |-> $past(switch_busy_o))
    else $error("source moved outside switch");
  chk_switch_cfg: assert property ($rose(switch_busy_o)
    |-> switch_monitor_config_i) else $error("switch while disabled");
endmodule
bind occ_ctrl occ_ctrl_assertions u_chk (.*);
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the oscillator control block.
// Drives APB and clock status inputs; no far-side model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ---------------------------------------------------------
  // Signals
  // ---------------------------------------------------------
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [3:0]  pstrb_i = 4'h0;
  logic        switch_monitor_config_i = 1'b1;
  logic        secondary_source_config_i = 1'b1;
  logic [2:0]  initial_source_config_i = 3'h5;
  logic        pll_locked_i = 1'b0;
  logic        pll_timer_ok_i = 1'b0;
  logic        clock_failed_i = 1'b0;
  logic        new_src_ready_i = 1'b0;
  logic        new_src_clk_i = 1'b0;
  logic [7:0]  pll_source_map_i = 8'h24;
  wire         pready_o, pslverr_o, irq_o, switch_busy_o;
  wire         secondary_osc_enable_o, secondary_osc_high_power_o;
  wire  [31:0] prdata_o;
  wire  [2:0]  current_source_select_o;
  logic [31:0] rd;
  int          fail_count = 0;
  int          num_checks = 0;

  occ_ctrl dut (.*);

  // 125 MHz system clock
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      $display("[FAIL] %0t bus answer timed out", $time);
      conclude();
    end
    rd = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e, mk,
                    input string m);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(rd & mk, e, m);
  endtask

  // Slow new-source clock, only while a switch waits on it
  task automatic pulses(input int k);
    repeat (k) begin
      cyc(4);
      new_src_clk_i <= 1'b1;
      cyc(4);
      new_src_clk_i <= 0;
    end
  endtask

  // Watchdog against a hung run
  initial begin
    cyc(50000);
    fail_count++;
    $display("[FAIL] %0t run timed out", $time);
    conclude();
  end

  // ---------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------
  initial begin
    cyc(6);
    rst_i <= 1'b0;
    cyc(2);
    rc(12'h000, 32'h0000_5500, 32'hFFFF_7F51, "reset ctrl");
    chk(current_source_select_o, 3'h5, "reset src");
    rc(12'h00C, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped");
    apb(1'b1, 12'h000, 32'h0000_0056, 4'h1);
    rc(12'h000, 32'h0000_0006, 32'h0000_0056, "ctrl bits");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      secondary_source_config_i <= i[2];
      apb(1'b1, 12'h000, {29'h0, i[1:0], 1'b0}, 4'h1);
      cyc(3);
      chk(secondary_osc_enable_o, i[0], "enable");
      chk(secondary_osc_high_power_o, i[1] & i[2], "drive");
    end
    $display("test oscillator done");
    for (int j = 0; j < 4; j++) begin
      pll_locked_i <= j[0];
      pll_timer_ok_i <= j[1];
      cyc(4);
      rc(12'h000, {26'h0, j != 0, 5'h0}, 32'h20, "pll lock");
    end
    pll_source_map_i <= 8'h04;
    cyc(4);
    rc(12'h000, 32'h0000_0000, 32'h20, "non pll");
    pll_source_map_i <= 8'h24;
    $display("test pll done");
    clock_failed_i <= 1'b1;
    cyc(4);
    clock_failed_i <= 1'b0;
    cyc(3);
    rc(12'h000, 32'h0000_0008, 32'h0000_0008, "fail flag");
    chk(irq_o, 1'b0, "irq masked");
    apb(1'b1, 12'h008, 32'h0000_0002, 4'h1);
    chk(irq_o, 1'b1, "irq raised");
    apb(1'b1, 12'h004, 32'h0000_0002, 4'h1);
    chk(irq_o, 1'b0, "irq cleared");
    $display("test fail done");
    apb(1'b1, 12'h000, 32'h0000_0007, 4'h1);
    cyc(4);
    rc(12'h000, 32'h0000_5500, 32'h0000_7701, "abort req");
    rc(12'h004, 32'h0000_0004, 32'h0000_0004, "abort stat");
    chk(switch_busy_o, 1'b0, "abort idle");
    apb(1'b1, 12'h004, 32'h0000_0004, 4'h1);
    $display("test abort done");
    apb(1'b1, 12'h000, 32'h0000_0200, 4'h2);
    apb(1'b1, 12'h000, 32'h0000_0007, 4'h1);
    cyc(3);
    chk(switch_busy_o, 1'b1, "switch busy");
    rc(12'h000, 32'h0000_5201, 32'h0000_7729, "in switch");
    new_src_ready_i <= 1'b1;
    pulses(9);
    chk(current_source_select_o, 3'h5, "early");
    pulses(3);
    for (int n = 0; n < 300 && switch_busy_o === 1'b1; n++)
      cyc(1);
    if (switch_busy_o !== 1'b0) begin
      fail_count++;
      $display("[FAIL] %0t switch never finished", $time);
      conclude();
    end
    new_src_ready_i <= 1'b0;
    chk(current_source_select_o, 3'h2, "new src");
    rc(12'h000, 32'h0000_2220, 32'h0000_7721, "after");
    rc(12'h004, 32'h0000_0001, 32'h0000_0001, "done stat");
    $display("test switch done");
    apb(1'b1, 12'h000, 32'h0000_0086, 4'h1);
    apb(1'b1, 12'h000, 32'h0000_0300, 4'h2);
    apb(1'b1, 12'h000, 32'h0000_0087, 4'h1);
    cyc(4);
    rc(12'h000, 32'h0000_2280, 32'h0000_7781, "locked");
    chk(current_source_select_o, 3'h2, "locked src");
    $display("test lock done");
    rst_i <= 1'b1;
    switch_monitor_config_i <= 1'b0;
    initial_source_config_i <= 3'h1;
    cyc(3);
    rst_i <= 1'b0;
    cyc(3);
    chk(current_source_select_o, 3'h1, "second reset");
    apb(1'b1, 12'h000, 32'h0000_0081, 4'h1);
    apb(1'b1, 12'h000, 32'h0000_0300, 4'h2);
    cyc(4);
    rc(12'h000, 32'h0000_1300, 32'h0000_7701, "no switch");
    chk(switch_busy_o, 1'b0, "stays idle");
    $display("test disabled done");
    conclude();
  end
endmodule
`default_nettype wire
